// >>> rtl/cpu_exception_sequencer.v
// Exception sequencer: ranking, reset sequence, stacking and vector fetch
`timescale 1ns/1ps
`default_nettype none
`include "exc_seq_defines.vh"

module cpu_exception_sequencer
(
  input wire pclk, // Clock, 100 MHz
  input wire presetn, // Asynchronous reset, active low
  input wire psel, // APB select
  input wire penable, // APB access phase
  input wire pwrite, // APB write
  input wire [11:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  output reg [31:0] prdata, // APB read data
  output wire pready, // APB ready, always one
  output wire pslverr, // APB error on unmapped address
  input wire chip_clear_input_n, // Reset pin, active low
  input wire watchdog_timer_ovf, // Watchdog overflow pulse
  input wire instr_boundary, // Instruction completes this cycle
  input wire flags_instr_done, // Completing one is a flags op
  input wire sleep_direct, // Sleep made a direct transition
  input wire trap_always_instr, // Trap instruction completes
  input wire [1:0] trap_num, // Trap field
  input wire nmi_req, // Nonmaskable request level
  input wire [7:0] external_request_lines, // External requests
  input wire int_req, // Internal request level
  input wire [6:0] int_vec, // Internal vector number
  output reg int_ack, // Interrupt accepted pulse
  output reg [6:0] exc_vector, // Vector number being served
  input wire [23:0] program_counter_in, // Return address
  input wire [7:0] condition_flags_in, // Flags to save
  input wire [23:0] stack_pointer_in, // Current stack pointer
  output reg [23:0] program_counter, // New program counter
  output reg pc_load, // Load program_counter pulse
  output reg [7:0] condition_flags_register, // New flags
  output reg flags_load, // Load flags pulse
  output reg [23:0] stack_pointer, // Stack pointer after pushes
  output reg sp_load, // Load stack_pointer pulse
  output wire cpu_hold, // Pipeline must stall
  output reg periph_init, // Peripheral register reset pulse
  input wire [7:0] periph_sel, // One-hot peripheral access
  output wire periph_access_en, // Access may take effect
  output reg mem_req, // Memory request level
  output reg mem_we, // Memory write
  output reg [23:0] mem_addr, // Memory byte address
  output reg [15:0] mem_wdata, // Memory write data
  input wire [15:0] mem_rdata, // Memory read data
  input wire mem_ack // Memory done pulse
);

  // Sequencer states
  localparam S_RUN = 3'd0;
  localparam S_HOLD = 3'd1;
  localparam S_INIT = 3'd2;
  localparam S_PUSH = 3'd3;
  localparam S_FETCH = 3'd4;
  localparam S_LOAD = 3'd5;

  reg [2:0] state_ff; // Sequencer state
  reg [1:0] kind_ff; // Kind being served
  reg [1:0] cnt_ff; // Word counter in push or fetch
  reg [23:0] sp_ff; // Working stack pointer
  reg [23:0] ret_pc_ff; // Captured return address
  reg [7:0] ret_ccr_ff; // Captured flags
  reg [15:0] vec_hi_ff; // Upper fetched word
  reg [31:0] sys_ctrl_ff; // System control register
  reg [7:0] module_halt_ctrl_ff; // Module halt control
  reg no_sample_ff; // Skip interrupt sampling once
  reg exc_end_ff; // Exception just ended, a boundary
  reg wdt_src_ff; // Last reset came from the watchdog
  reg [6:0] vec_ff; // Vector number in service

  wire adv_mode; // Advanced addressing mode
  wire mode_one; // Interrupt control mode 1
  wire boundary; // An instruction or sequence ends
  wire int_ok; // Interrupts may be sampled now
  wire arb_take;
  wire [1:0] arb_kind;
  wire [6:0] arb_vec;
  wire [23:0] vec_addr;
  wire [23:0] sp_dec;
  wire [1:0] push_words;
  wire [1:0] fetch_words;
  wire apb_wr;
  wire addr_hit;

  assign adv_mode = sys_ctrl_ff[`SYS_ADV_BIT];
  // The mode pair sits in the system control word
  assign mode_one = ({sys_ctrl_ff[`SYS_MODE_HI_BIT], sys_ctrl_ff[`SYS_MODE_LO_BIT]}
    == `INT_MODE_ONE);

  // Boundaries are instruction ends and the end of a sequence
  assign boundary = (state_ff == S_RUN) && (instr_boundary || exc_end_ff);
  // Flag-logic ends and the post-reset boundary are never sampled
  assign int_ok = boundary && !no_sample_ff && !(instr_boundary && flags_instr_done);

  // Pick one exception; traps and transitions need a running CPU
  exc_priority_arbiter u_arb
  (
    .nmi_req(nmi_req),
    .external_request_lines(external_request_lines),
    .int_req(int_req),
    .int_vec(int_vec),
    .int_ok(int_ok),
    .dt_req(sleep_direct && state_ff == S_RUN),
    .trap_req(trap_always_instr && state_ff == S_RUN),
    .trap_num(trap_num),
    .take(arb_take),
    .kind(arb_kind),
    .vec(arb_vec)
  );

  // Entry address of the vector in service
  vector_addr_gen u_vag
  (
    .vec(vec_ff),
    .advanced(adv_mode),
    .addr(vec_addr)
  );

  // Pushes go one word below the working pointer
  assign sp_dec = sp_ff - `STACK_STEP;
  // Advanced mode saves a longword counter, normal mode a word
  assign push_words = adv_mode ? 2'd3 : 2'd2;
  assign fetch_words = adv_mode ? 2'd2 : 2'd1;

  // Pipeline runs only while no sequence is active
  assign cpu_hold = (state_ff != S_RUN);

  // A halted module sees neither reads nor writes
  assign periph_access_en = |(periph_sel & ~module_halt_ctrl_ff);

  // APB: zero wait states, error on unmapped offsets
  assign pready = 1'b1;
  assign addr_hit = (paddr == `OFF_SYS_CTRL) || (paddr == `OFF_MOD_HALT)
    || (paddr == `OFF_STATUS);
  assign pslverr = psel && penable && !addr_hit;
  assign apb_wr = psel && penable && pwrite;

  // Read mux; status shows the sequencer's own state
  always @*
  begin
    prdata = 32'h0000_0000;
    if (psel && !pwrite)
    begin
      case (paddr)
        `OFF_SYS_CTRL: prdata = sys_ctrl_ff;
        `OFF_MOD_HALT: prdata = {24'h00_0000, module_halt_ctrl_ff};
        `OFF_STATUS: prdata = {15'h0000, wdt_src_ff, 1'b0, vec_ff, 5'h00, state_ff};
        default: prdata = 32'h0000_0000;
      endcase
    end
  end

  // Software control registers; reset restores halt state
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sys_ctrl_ff <= `SYS_CTRL_RST;
      module_halt_ctrl_ff <= `MOD_HALT_RST;
    end
    else if (state_ff == S_HOLD || state_ff == S_INIT)
    begin
      // Reset handling also clears software settings
      sys_ctrl_ff <= `SYS_CTRL_RST;
      module_halt_ctrl_ff <= `MOD_HALT_RST;
    end
    else if (apb_wr && paddr == `OFF_SYS_CTRL)
    begin
      // Only the mode field and addressing bit are writable
      sys_ctrl_ff <= pwdata & 32'h0000_0031;
    end
    else if (apb_wr && paddr == `OFF_MOD_HALT)
    begin
      module_halt_ctrl_ff <= pwdata[7:0];
    end
  end

  // Main sequencer
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff <= S_HOLD;
      kind_ff <= `KIND_RESET;
      cnt_ff <= 2'd0;
      sp_ff <= 24'h00_0000;
      ret_pc_ff <= 24'h00_0000;
      ret_ccr_ff <= 8'h00;
      vec_hi_ff <= 16'h0000;
      vec_ff <= `VEC_RESET;
      no_sample_ff <= 1'b1;
      exc_end_ff <= 1'b0;
      wdt_src_ff <= 1'b0;
      int_ack <= 1'b0;
      exc_vector <= `VEC_RESET;
      program_counter <= 24'h00_0000;
      pc_load <= 1'b0;
      condition_flags_register <= 8'h00;
      flags_load <= 1'b0;
      stack_pointer <= 24'h00_0000;
      sp_load <= 1'b0;
      periph_init <= 1'b0;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 24'h00_0000;
      mem_wdata <= 16'h0000;
    end
    else
    begin
      // Pulses last one cycle unless set below
      int_ack <= 1'b0;
      pc_load <= 1'b0;
      flags_load <= 1'b0;
      sp_load <= 1'b0;
      periph_init <= 1'b0;
      exc_end_ff <= 1'b0;
      if (!chip_clear_input_n)
      begin
        // Pin low: freeze everything and drop any bus request
        state_ff <= S_HOLD;
        mem_req <= 1'b0;
        wdt_src_ff <= 1'b0;
        no_sample_ff <= 1'b1;
      end
      else if (watchdog_timer_ovf)
      begin
        // Watchdog overflow restarts reset handling at once
        state_ff <= S_INIT;
        mem_req <= 1'b0;
        wdt_src_ff <= 1'b1;
        no_sample_ff <= 1'b1;
      end
      else
      begin
        case (state_ff)
          S_HOLD:
          begin
            // Pin has risen; a too-short pulse is the outside's fault
            state_ff <= S_INIT;
          end
          S_INIT:
          begin
            // Initialise CPU and peripherals, mask interrupts
            periph_init <= 1'b1;
            condition_flags_register <= 8'h80;
            flags_load <= 1'b1;
            kind_ff <= `KIND_RESET;
            vec_ff <= `VEC_RESET;
            exc_vector <= `VEC_RESET;
            cnt_ff <= 2'd0;
            state_ff <= S_FETCH;
          end
          S_RUN:
          begin
            // An instruction boundary clears the post-reset block
            if (boundary && instr_boundary)
              no_sample_ff <= 1'b0;
            if (arb_take)
            begin
              kind_ff <= arb_kind;
              vec_ff <= arb_vec;
              exc_vector <= arb_vec;
              int_ack <= (arb_kind == `KIND_INT);
              ret_pc_ff <= program_counter_in;
              ret_ccr_ff <= condition_flags_in;
              // Odd pointers are silently forced even
              sp_ff <= {stack_pointer_in[23:1], 1'b0};
              cnt_ff <= 2'd0;
              // Direct transition goes to its vector with no stacking
              state_ff <= (arb_kind == `KIND_DIRECT) ? S_FETCH : S_PUSH;
            end
          end
          S_PUSH:
          begin
            // Counter low word first, then high word in advanced mode, flags last
            if (!mem_req)
            begin
              mem_req <= 1'b1;
              mem_we <= 1'b1;
              mem_addr <= sp_dec;
              if (cnt_ff == push_words - 2'd1)
                mem_wdata <= {ret_ccr_ff, ret_ccr_ff};
              else if (cnt_ff == 2'd0)
                mem_wdata <= ret_pc_ff[15:0];
              else
                mem_wdata <= {8'h00, ret_pc_ff[23:16]};
            end
            else if (mem_ack)
            begin
              mem_req <= 1'b0;
              sp_ff <= sp_dec;
              if (cnt_ff == push_words - 2'd1)
              begin
                cnt_ff <= 2'd0;
                stack_pointer <= sp_dec;
                sp_load <= 1'b1;
                state_ff <= S_FETCH;
              end
              else
                cnt_ff <= cnt_ff + 2'd1;
            end
          end
          S_FETCH:
          begin
            // Read the entry, high word first in advanced mode
            if (!mem_req)
            begin
              mem_req <= 1'b1;
              mem_we <= 1'b0;
              mem_addr <= vec_addr + {21'h00_0000, cnt_ff, 1'b0};
            end
            else if (mem_ack)
            begin
              mem_req <= 1'b0;
              vec_hi_ff <= mem_rdata;
              if (cnt_ff == fetch_words - 2'd1)
              begin
                // Low word is taken while it stands with the acknowledge
                program_counter <= adv_mode ? {vec_hi_ff[7:0], mem_rdata}
                  : {8'h00, mem_rdata};
                state_ff <= S_LOAD;
              end
              else
                cnt_ff <= cnt_ff + 2'd1;
            end
          end
          S_LOAD:
          begin
            // Counter already holds the entry; publish it now
            pc_load <= 1'b1;
            state_ff <= S_RUN;
            if (kind_ff == `KIND_RESET)
              no_sample_ff <= 1'b1;
            else
            begin
              exc_end_ff <= 1'b1;
              // Mask bit always set; user bit only in mode 1
              condition_flags_register <= ret_ccr_ff | 8'h80
                | (mode_one ? 8'h40 : 8'h00);
              flags_load <= (kind_ff != `KIND_DIRECT);
            end
          end
          default:
          begin
            state_ff <= S_HOLD;
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// >>> rtl/exc_seq_defines.vh
// Constants shared by the exception sequencer files
`ifndef EXC_SEQ_DEFINES_VH
`define EXC_SEQ_DEFINES_VH

// Register byte offsets on the register bus
`define OFF_SYS_CTRL 12'h000
`define OFF_MOD_HALT 12'h004
`define OFF_STATUS 12'h008

// System control fields
`define SYS_ADV_BIT 0
`define SYS_MODE_LO_BIT 4
`define SYS_MODE_HI_BIT 5
`define SYS_CTRL_RST 32'h0000_0000
// Mode field value that selects interrupt control mode 1
`define INT_MODE_ONE 2'h2

// Module halt control, every module halted after reset
`define MOD_HALT_RST 8'hFF

// Flags register bit positions
`define FLAG_I_BIT 7
`define FLAG_UI_BIT 6

// Vector numbers
`define VEC_RESET 7'h00
`define VEC_DIRECT 7'h06
`define VEC_NMI 7'h07
`define VEC_TRAP_BASE 7'h08
`define VEC_EXT_BASE 7'h10
`define VEC_INT_FIRST 7'h18
`define VEC_INT_LAST 7'h6B

// Exception kinds
`define KIND_INT 2'h0
`define KIND_DIRECT 2'h1
`define KIND_TRAP 2'h2
`define KIND_RESET 2'h3

// Stack word step in bytes
`define STACK_STEP 24'h00_0002

`endif

// >>> rtl/exc_priority_arbiter.v
// Ranks pending exceptions at a boundary and picks one vector number
`timescale 1ns/1ps
`default_nettype none
`include "exc_seq_defines.vh"

module exc_priority_arbiter
(
  input wire nmi_req, // Nonmaskable request level
  input wire [7:0] external_request_lines, // External request levels
  input wire int_req, // Internal peripheral request
  input wire [6:0] int_vec, // Internal request vector number
  input wire int_ok, // Interrupt sampling allowed here
  input wire dt_req, // Direct transition from sleep
  input wire trap_req, // Trap instruction executed
  input wire [1:0] trap_num, // Trap field 0 to 3
  output reg take, // Some exception is chosen
  output reg [1:0] kind, // Kind of chosen exception
  output reg [6:0] vec // Vector number of chosen one
);

  integer i;
  reg ext_hit;
  reg [6:0] ext_vec;
  wire int_in_range;

  // Out-of-range internal numbers are ignored rather than aliased
  assign int_in_range = (int_vec >= `VEC_INT_FIRST) && (int_vec <= `VEC_INT_LAST);

  // Lowest numbered external line wins among the lines
  always @*
  begin
    ext_hit = 1'b0;
    ext_vec = `VEC_EXT_BASE;
    for (i = 7; i >= 0; i = i - 1)
    begin
      if (external_request_lines[i])
      begin
        ext_hit = 1'b1;
        ext_vec = `VEC_EXT_BASE + i[6:0];
      end
    end
  end

  // Interrupt over direct transition over trap
  always @*
  begin
    take = 1'b1;
    kind = `KIND_INT;
    vec = `VEC_NMI;
    if (int_ok && nmi_req)
      vec = `VEC_NMI;
    else if (int_ok && ext_hit)
      vec = ext_vec;
    else if (int_ok && int_req && int_in_range)
      vec = int_vec;
    else if (dt_req)
    begin
      kind = `KIND_DIRECT;
      vec = `VEC_DIRECT;
    end
    else if (trap_req)
    begin
      kind = `KIND_TRAP;
      vec = `VEC_TRAP_BASE + {5'h00, trap_num};
    end
    else
      take = 1'b0;
  end

endmodule
`default_nettype wire

// >>> rtl/vector_addr_gen.v
// Turns a vector number into the byte address of its table entry
`timescale 1ns/1ps
`default_nettype none
`include "exc_seq_defines.vh"

module vector_addr_gen
(
  input wire [6:0] vec, // Vector number
  input wire advanced, // 1 selects four-byte entries
  output wire [23:0] addr // Entry byte address
);

  // Two bytes per entry in normal mode, four in advanced
  assign addr = advanced ? {15'h0000, vec, 2'b00} : {16'h0000, vec, 1'b0};

endmodule
`default_nettype wire

// >>> test/cpu_exception_sequencer_asserts.sv
// Checker for the exception sequencer port behaviour
`timescale 1ns/1ps
`default_nettype none
`include "exc_seq_defines.vh"
module cpu_exception_sequencer_asserts
(
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic chip_clear_input_n, // Reset pin
  input wire logic watchdog_timer_ovf, // Watchdog pulse
  input wire logic instr_boundary, // Boundary pulse
  input wire logic flags_instr_done, // Flags op ends
  input wire logic nmi_req, // Nonmaskable level
  input wire logic [7:0] external_request_lines, // Line levels
  input wire logic int_ack, // Accept pulse
  input wire logic [6:0] exc_vector, // Vector served
  input wire logic [7:0] condition_flags_register, // New flags
  input wire logic flags_load, // Flags pulse
  input wire logic pc_load, // Counter pulse
  input wire logic cpu_hold, // Stall level
  input wire logic periph_init, // Peripheral reset
  input wire logic mem_req, // Memory request
  input wire logic [23:0] mem_addr, // Memory address
  input wire logic mem_ack // Memory done
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  hold_in_reset_a: assert property (!chip_clear_input_n |=> cpu_hold && !mem_req)
    else $error("sequencer active while pin low");
  pin_rise_a: assert property ($rose(chip_clear_input_n) |-> ##[1:3] periph_init)
    else $error("no reset sequence after pin rise");
  dog_reset_a: assert property (watchdog_timer_ovf && chip_clear_input_n
    |-> ##[1:3] periph_init)
    else $error("no reset sequence after watchdog");
  reset_mask_a: assert property (periph_init
    |-> flags_load && condition_flags_register == 8'h80)
    else $error("reset did not set mask bit only");
  flag_skip_a: assert property (instr_boundary && flags_instr_done && !cpu_hold
    |=> !int_ack)
    else $error("interrupt taken after flags op");
  ack_at_edge_a: assert property (int_ack |-> $past(instr_boundary) || $past(pc_load))
    else $error("interrupt taken off a boundary");
  ack_stall_a: assert property (int_ack |-> cpu_hold ##1 cpu_hold)
    else $error("no stall after accept");
  nmi_first_a: assert property (int_ack && $past(nmi_req) |-> exc_vector == `VEC_NMI)
    else $error("nonmaskable not served first");
  line_vec_a: assert property (int_ack && !$past(nmi_req)
    && $past(external_request_lines) != 8'h00
    |-> exc_vector >= `VEC_EXT_BASE && exc_vector <= 7'h17)
    else $error("line request got wrong vector");
  end_run_a: assert property (pc_load |-> ##[0:1] !cpu_hold)
    else $error("no resume after counter load");
  even_addr_a: assert property (mem_req |-> !mem_addr[0])
    else $error("odd memory address");
  mem_hold_a: assert property (mem_req && !mem_ack && chip_clear_input_n
    && !watchdog_timer_ovf |=> mem_req && $stable(mem_addr))
    else $error("memory request dropped early");
  trap_mask_a: assert property (flags_load
    |-> condition_flags_register[`FLAG_I_BIT])
    else $error("mask bit clear on flags load");
endmodule
bind cpu_exception_sequencer cpu_exception_sequencer_asserts chk (.*);
`default_nettype wire

// >>> test/exc_mem_model.sv
// Memory partner answering the sequencer's word requests
`timescale 1ns/1ps
`default_nettype none
module exc_mem_model
(
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic mem_req, // Request level
  input wire logic mem_we, // Write
  input wire logic [23:0] mem_addr, // Byte address
  input wire logic [3:0] lat, // Wait cycles before answer
  output logic [15:0] mem_rdata, // Read data, valid with ack
  output logic mem_ack // Done pulse
);
  logic [3:0] wait_ff; // Cycles waited on this request
  // Answer after lat cycles; data toggles between answers so stale data never passes
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wait_ff <= 4'h0;
      mem_ack <= 1'b0;
      mem_rdata <= 16'h0000;
    end
    else
    begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack && wait_ff >= lat)
      begin
        mem_ack <= 1'b1;
        wait_ff <= 4'h0;
        // Table words carry their own low address byte
        if (!mem_we)
          mem_rdata <= {8'hC3, mem_addr[7:0]};
      end
      else if (mem_req && !mem_ack)
        wait_ff <= wait_ff + 4'h1;
    end
  end
endmodule
`default_nettype wire

// >>> test/cpu_exception_sequencer_test.sv
// Self-checking bench for the exception sequencer
`timescale 1ns/1ps
`default_nettype none
`include "exc_seq_defines.vh"
module cpu_exception_sequencer_test;
  logic pclk = 1'b0, presetn = 1'b0; // Clock and reset
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // Bus controls
  logic [11:0] paddr = 12'h000; // Bus address
  logic [31:0] pwdata = 32'h0000_0000; // Bus write data
  logic chip_clear_input_n = 1'b1, watchdog_timer_ovf = 1'b0; // Reset sources
  logic instr_boundary = 1'b0, flags_instr_done = 1'b0; // Pipeline status
  logic sleep_direct = 1'b0, trap_always_instr = 1'b0; // Exception pulses
  logic [1:0] trap_num = 2'h0; // Trap field
  logic nmi_req = 1'b0, int_req = 1'b0; // Request levels
  logic [7:0] external_request_lines = 8'h00; // Line requests
  logic [6:0] int_vec = 7'h00; // Internal vector
  logic [23:0] program_counter_in = 24'h12_3456; // Return address
  logic [7:0] condition_flags_in = 8'h05; // Flags to save
  logic [23:0] stack_pointer_in = 24'h00_8001; // Odd on purpose
  logic [7:0] periph_sel = 8'h00; // Peripheral access
  logic [3:0] lat = 4'h0; // Memory latency
  wire [31:0] prdata; // Bus read data
  wire pready, pslverr, int_ack, pc_load, flags_load, sp_load; // Pulses and flags
  wire cpu_hold, periph_init, periph_access_en, mem_req, mem_we, mem_ack; // Levels
  wire [6:0] exc_vector; // Vector served
  wire [23:0] program_counter, stack_pointer, mem_addr; // Addresses
  wire [7:0] condition_flags_register; // New flags
  wire [15:0] mem_wdata, mem_rdata; // Memory data
  int bad_count = 0, n_compared = 0; // Tallies

  cpu_exception_sequencer dut (.*);
  exc_mem_model mem (.*);

  // Free-running 100 MHz clock
  initial
    forever #5 pclk = ~pclk;

  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One bus transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (i == 50)
      begin bad_count++; report_and_stop(); end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // One instruction boundary carrying optional flags, trap and sleep marks
  task automatic bnd(input logic f, input logic t, input logic s);
    @(posedge pclk);
    instr_boundary <= 1'b1;
    flags_instr_done <= f;
    trap_always_instr <= t;
    sleep_direct <= s;
    @(posedge pclk);
    instr_boundary <= 1'b0;
    flags_instr_done <= 1'b0;
    trap_always_instr <= 1'b0;
    sleep_direct <= 1'b0;
  endtask

  // Nothing may be taken: the pipeline keeps running
  task automatic quiet(input string nm);
    repeat (3) @(posedge pclk);
    #1;
    check(nm, 32'h0000_0000, cpu_hold);
  endtask

  // Follow one exception to its counter load and judge stack, vector and flags
  task automatic expect_exc(input logic [6:0] v, input logic ak, input logic adv,
    input int nw, input logic [7:0] fl);
    int i;
    logic sa;
    logic [7:0] fv;
    logic [23:0] sp, a, pc;
    logic [23:0] wa[$];
    logic [15:0] wd[$];
    sa = 1'b0;
    fv = 8'h00;
    sp = 24'h00_0000;
    for (i = 0; i < 400; i++)
    begin
      #1;
      if (int_ack === 1'b1)
      begin
        sa = 1'b1;
        // Requester drops its request on accept
        if (exc_vector == `VEC_NMI)
          nmi_req <= 1'b0;
        else if (exc_vector[6:3] == 4'h2)
          external_request_lines[exc_vector[2:0]] <= 1'b0;
        else
          int_req <= 1'b0;
      end
      if (flags_load === 1'b1)
        fv = condition_flags_register;
      if (mem_req === 1'b1 && mem_ack === 1'b1 && mem_we === 1'b1)
      begin
        wa.push_back(mem_addr);
        wd.push_back(mem_wdata);
      end
      if (sp_load === 1'b1)
        sp = stack_pointer;
      if (pc_load === 1'b1)
        break;
      @(posedge pclk);
    end
    if (i == 400)
      begin bad_count++; report_and_stop(); end
    a = adv ? {15'h0000, v, 2'b00} : {16'h0000, v, 1'b0};
    pc = adv ? {a[7:0], 8'hC3, a[7:0] + 8'h02} : {8'h00, 8'hC3, a[7:0]};
    check("vector", v, exc_vector);
    if (ak)
      check("accepted", 32'h0000_0001, sa);
    check("new pc", pc, program_counter);
    check("flags", fl, fv);
    check("pushes", nw, wa.size());
    if (nw > 0 && wa.size() == nw)
    begin
      check("first push", 24'h00_7FFE, wa[0]);
      check("pc word", program_counter_in[15:0], wd[0]);
      check("last push", 24'h00_8000 - 2 * nw, wa[nw - 1]);
      check("flag word", {2{condition_flags_in}}, wd[nw - 1]);
      check("new sp", 24'h00_8000 - 2 * nw, sp);
      if (nw == 3)
        check("pc high", program_counter_in[23:16], wd[1]);
    end
    @(posedge pclk);
  endtask

  // Register map, unmapped place and module halt gating
  task automatic t_regs;
    logic [31:0] r;
    logic e;
    apb(1'b1, `OFF_SYS_CTRL, 32'hFFFF_FFFF, r, e);
    apb(1'b0, `OFF_SYS_CTRL, 32'h0000_0000, r, e);
    check("sys ctrl", 32'h0000_0031, r);
    apb(1'b0, 12'h00C, 32'h0000_0000, r, e);
    check("unmapped err", 32'h0000_0001, e);
    check("unmapped data", 32'h0000_0000, r);
    apb(1'b0, `OFF_MOD_HALT, 32'h0000_0000, r, e);
    check("halt reset", 32'h0000_00FF, r);
    periph_sel <= 8'h01;
    #1;
    check("halted access", 32'h0000_0000, periph_access_en);
    apb(1'b1, `OFF_MOD_HALT, 32'h0000_00FE, r, e);
    #1;
    check("released access", 32'h0000_0001, periph_access_en);
    periph_sel <= 8'h02;
    #1;
    check("other halted", 32'h0000_0000, periph_access_en);
    apb(1'b1, `OFF_SYS_CTRL, 32'h0000_0000, r, e);
    $display("register test done");
  endtask

  // Interrupt requests of every kind, ranked and refused
  task automatic t_ints;
    nmi_req <= 1'b1;
    bnd(1'b0, 1'b0, 1'b0);
    quiet("first instr runs");
    bnd(1'b0, 1'b0, 1'b0);
    expect_exc(`VEC_NMI, 1'b1, 1'b0, 2, 8'h85);
    external_request_lines <= 8'h01;
    bnd(1'b1, 1'b0, 1'b0);
    quiet("flags op boundary");
    bnd(1'b0, 1'b0, 1'b0);
    expect_exc(`VEC_EXT_BASE, 1'b1, 1'b0, 2, 8'h85);
    lat <= 4'h3;
    external_request_lines <= 8'h0C;
    int_req <= 1'b1;
    int_vec <= 7'h1E;
    bnd(1'b0, 1'b0, 1'b0);
    expect_exc(7'h12, 1'b1, 1'b0, 2, 8'h85);
    expect_exc(7'h13, 1'b1, 1'b0, 2, 8'h85);
    expect_exc(7'h1E, 1'b1, 1'b0, 2, 8'h85);
    lat <= 4'h0;
    int_req <= 1'b1;
    int_vec <= 7'h6C;
    bnd(1'b0, 1'b0, 1'b0);
    quiet("vector out of range");
    int_vec <= `VEC_INT_LAST;
    bnd(1'b0, 1'b0, 1'b0);
    expect_exc(`VEC_INT_LAST, 1'b1, 1'b0, 2, 8'h85);
    $display("interrupt test done");
  endtask

  // Direct transition, then all four traps, alternating normal and advanced mode
  task automatic t_traps;
    logic [31:0] r;
    logic e;
    int n;
    bnd(1'b0, 1'b0, 1'b1);
    expect_exc(`VEC_DIRECT, 1'b0, 1'b0, 0, 8'h00);
    for (n = 0; n < 4; n++)
    begin
      apb(1'b1, `OFF_SYS_CTRL, n[0] ? 32'h0000_0021 : 32'h0000_0000, r, e);
      lat <= n[1] ? 4'h2 : 4'h0;
      trap_num <= n[1:0];
      bnd(1'b0, 1'b1, 1'b0);
      expect_exc(`VEC_TRAP_BASE + n[6:0], 1'b0, n[0], n[0] ? 3 : 2,
        n[0] ? 8'hC5 : 8'h85);
    end
    $display("trap test done");
  endtask

  // Reset pin held low mid-run, then a watchdog overflow
  task automatic t_resets;
    logic [31:0] r;
    logic e;
    apb(1'b1, `OFF_MOD_HALT, 32'h0000_0000, r, e);
    @(posedge pclk);
    chip_clear_input_n <= 1'b0;
    repeat (20) @(posedge pclk);
    #1;
    check("hold in reset", 32'h0000_0001, cpu_hold);
    check("no memory", 32'h0000_0000, mem_req);
    apb(1'b0, `OFF_MOD_HALT, 32'h0000_0000, r, e);
    check("halt restored", 32'h0000_00FF, r);
    @(posedge pclk);
    chip_clear_input_n <= 1'b1;
    expect_exc(`VEC_RESET, 1'b0, 1'b0, 0, 8'h80);
    @(posedge pclk);
    watchdog_timer_ovf <= 1'b1;
    @(posedge pclk);
    watchdog_timer_ovf <= 1'b0;
    expect_exc(`VEC_RESET, 1'b0, 1'b0, 0, 8'h80);
    $display("reset test done");
  endtask

  // Main sequence
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    expect_exc(`VEC_RESET, 1'b0, 1'b0, 0, 8'h80);
    t_regs();
    t_ints();
    t_traps();
    t_resets();
    report_and_stop();
  end
endmodule
`default_nettype wire
